/* logic/hwpcd_pkg.sv */
/*
 Shared constants, enumerations and carrier structs of the hardware pin
 configuration decoder. Assumes a 10 MHz core clock.
*/
`default_nettype none
package hwpcd_pkg;
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned RESET_MIN_NS = 100;
    // Minimum reset time is rounded down, never below one cycle.
    localparam int unsigned RESET_CYC_RAW = RESET_MIN_NS / CLK_PERIOD_NS;
    localparam logic [3:0] RESET_CYCLES = (RESET_CYC_RAW < 1) ? 4'h1 : RESET_CYC_RAW[3:0];
    localparam logic [1:0] MODE_HW = 2'h0;
    localparam logic [1:0] MODE_SERIAL = 2'h1;
    localparam logic [1:0] MODE_PAR_STROBE = 2'h2;
    localparam logic [1:0] MODE_PAR_RDWR = 2'h3;
    localparam logic [1:0] TXSEL_NORMAL = 2'h0;
    localparam logic [1:0] TXSEL_ONES = 2'h1;
    localparam logic [1:0] TXSEL_PRBS = 2'h2;
    localparam logic [1:0] JIT_OFF = 2'h0;
    localparam logic [1:0] JIT_RX_WIDE = 2'h1;
    localparam logic [1:0] JIT_RX_NARROW = 2'h2;
    localparam logic [7:0] FIFO_DEPTH_64 = 8'h40;
    localparam logic [7:0] FIFO_DEPTH_128 = 8'h80;
    localparam logic [5:0] REACH_SHORT_DB = 6'h0a;
    localparam logic [5:0] REACH_LONG_T1_DB = 6'h24;
    localparam logic [5:0] REACH_LONG_E1_DB = 6'h2b;
    localparam logic [7:0] SW_RESET_VAL = 8'h00;

    typedef enum logic [1:0] {
        HWPCD_TXP_NORMAL,
        HWPCD_TXP_ONES,
        HWPCD_TXP_PRBS,
        HWPCD_TXP_OFF
    } hwpcd_txp_t;

    typedef struct packed {
        logic [1:0] mode_sel;
        logic equalizer_reach_sel;
        logic rx_powerdown_pin;
        logic [1:0] tx_pattern_sel;
        logic [1:0] jitter_atten_sel;
        logic e1_mode;
    } hwpcd_pins_t;

    typedef struct packed {
        logic hw_mode;
        logic long_reach;
        logic [5:0] reach_db;
        logic rx_powerdown;
        hwpcd_txp_t tx_pattern;
        logic jit_enable;
        logic jit_in_tx;
        logic jit_narrow;
        logic [7:0] jit_fifo_bits;
    } hwpcd_cfg_t;
endpackage
`default_nettype wire

/* logic/hwpcd_regfile.sv */
/*
 Small register store reached by the multiplexed address/data bus.
 Assumes the caller decodes cycles; read data come out of a register.
*/
`timescale 1ns/10ps
`default_nettype none
module hwpcd_regfile
    import hwpcd_pkg::*;
(
    input wire logic clock, // core clock
    input wire logic rst_n, // asynchronous reset, active low
    input wire logic [2:0] addr, // word address
    input wire logic [7:0] wdata, // write data
    input wire logic we, // write enable
    output logic [7:0] rdata // registered read data
);
    logic [7:0] mem_reg [8];
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    always_comb
    begin
        rdata_next = mem_reg[addr];
    end

    genvar i;
    generate
        for (i = 0; i < 8; i++)
        begin : g_word
            always_ff @(posedge clock or negedge rst_n)
            begin
                if (!rst_n)
                    mem_reg[i] <= SW_RESET_VAL;
                else if (we && addr == 3'(i))
                    mem_reg[i] <= wdata;
            end
        end
    endgenerate

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            rdata_reg <= SW_RESET_VAL;
        else
            rdata_reg <= rdata_next;
    end

    assign rdata = rdata_reg;
endmodule
`default_nettype wire

/* logic/hwpcd_top.sv */
/*
 Pin-level configuration decoder and multiplexed host bus of a single
 channel line interface. Assumes all pins are synchronous to clock.
*/
// How it works
// - Eight bus pins carry address first, then data, in both parallel styles.
// - Equalizer pin low gives 10 dB short reach; high gives 36/43 dB.
// - Receiver power-down pin 0 runs receiver, 1 powers it down.
// - Pattern select: 00 normal, 01 all ones, 10 PRBS, 11 transmitter off.
// - Jitter select: off, rx wide 64, rx narrow 128, tx narrow 128.
// - Jitter select pins are obeyed only in hardware control mode.
// - Reset low longer than 100 ns puts the device in reset.
// - Mode select: 00 pins, 01 serial, 10 strobe plus direction, 11 strobes.
// - Separate-strobe style drives read data from the edge after read strobe falls to the edge after it rises.
`timescale 1ns/10ps
`default_nettype none
module hwpcd_top
    import hwpcd_pkg::*;
(
    input wire logic clock, // 10 MHz core clock
    input wire logic rst_n, // hardware reset, active low
    input wire hwpcd_pkg::hwpcd_pins_t pins, // strap and mode pins
    input wire logic chip_sel_n, // bus chip select, active low
    input wire logic addr_latch, // address latch / strobe, high latches
    input wire logic data_strobe_n, // data strobe or read strobe, active low
    input wire logic rw_wr_n, // direction (strobe style) or write strobe
    input wire logic [7:0] ad_in, // bus level seen on pins
    output logic [7:0] ad_out, // bus drive value
    output logic ad_oe, // bus drive enable, high drives
    output hwpcd_pkg::hwpcd_cfg_t cfg, // decoded configuration
    output logic in_reset // device held in reset
);
    hwpcd_pins_t pins_reg, pins_next;
    hwpcd_cfg_t cfg_reg, cfg_next;
    logic [3:0] rst_cnt_reg, rst_cnt_next;
    logic in_reset_reg, in_reset_next;
    logic [2:0] addr_reg, addr_next;
    logic [7:0] ad_out_reg, ad_out_next;
    logic ad_oe_reg, ad_oe_next;
    logic strobe_d_reg, strobe_d_next;
    logic [7:0] rf_rdata;
    logic par_mode, read_cyc, write_cyc, strobe_act;

    // Reset acts at once through the asynchronous clear. After release the
    // state stays in reset for RESET_CYCLES + 1 edges, so the straps are sampled
    // cleanly before any decode or bus cycle is honoured.
    always_comb
    begin
        rst_cnt_next = rst_cnt_reg;
        in_reset_next = in_reset_reg;
        if (rst_cnt_reg < RESET_CYCLES)
            rst_cnt_next = rst_cnt_reg + 4'h1;
        else
            in_reset_next = 1'b0;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_cnt_reg <= 4'h0;
            in_reset_reg <= 1'b1;
        end
        else
        begin
            rst_cnt_reg <= rst_cnt_next;
            in_reset_reg <= in_reset_next;
        end
    end

    // Pin sampling and decode. The straps pass one flop stage before they are
    // decoded, so a strap change shows on cfg two edges later.
    always_comb
    begin
        pins_next = pins;
        cfg_next = cfg_reg;
        cfg_next.hw_mode = (pins_reg.mode_sel == MODE_HW);
        if (pins_reg.mode_sel == MODE_HW)
        begin
            cfg_next.long_reach = pins_reg.equalizer_reach_sel;
            if (!pins_reg.equalizer_reach_sel)
                cfg_next.reach_db = REACH_SHORT_DB;
            else if (pins_reg.e1_mode)
                cfg_next.reach_db = REACH_LONG_E1_DB;
            else
                cfg_next.reach_db = REACH_LONG_T1_DB;
            cfg_next.rx_powerdown = pins_reg.rx_powerdown_pin;
            case (pins_reg.tx_pattern_sel)
                TXSEL_NORMAL: cfg_next.tx_pattern = HWPCD_TXP_NORMAL;
                TXSEL_ONES: cfg_next.tx_pattern = HWPCD_TXP_ONES;
                TXSEL_PRBS: cfg_next.tx_pattern = HWPCD_TXP_PRBS;
                default: cfg_next.tx_pattern = HWPCD_TXP_OFF;
            endcase
            // Wide bandwidth goes with the short FIFO; both narrow settings use the long one.
            case (pins_reg.jitter_atten_sel)
                JIT_OFF:
                begin
                    cfg_next.jit_enable = 1'b0;
                    cfg_next.jit_in_tx = 1'b0;
                    cfg_next.jit_narrow = 1'b0;
                    cfg_next.jit_fifo_bits = 8'h00;
                end
                JIT_RX_WIDE:
                begin
                    cfg_next.jit_enable = 1'b1;
                    cfg_next.jit_in_tx = 1'b0;
                    cfg_next.jit_narrow = 1'b0;
                    cfg_next.jit_fifo_bits = FIFO_DEPTH_64;
                end
                JIT_RX_NARROW:
                begin
                    cfg_next.jit_enable = 1'b1;
                    cfg_next.jit_in_tx = 1'b0;
                    cfg_next.jit_narrow = 1'b1;
                    cfg_next.jit_fifo_bits = FIFO_DEPTH_128;
                end
                default:
                begin
                    cfg_next.jit_enable = 1'b1;
                    cfg_next.jit_in_tx = 1'b1;
                    cfg_next.jit_narrow = 1'b1;
                    cfg_next.jit_fifo_bits = FIFO_DEPTH_128;
                end
            endcase
        end
        else
        begin
            // Software control: the reach, power and pattern fields keep their
            // last strap values, while the jitter stage rests off.
            cfg_next.jit_enable = 1'b0;
            cfg_next.jit_in_tx = 1'b0;
            cfg_next.jit_narrow = 1'b0;
            cfg_next.jit_fifo_bits = 8'h00;
        end
        // Nothing decoded is shown while the device sits in reset.
        if (in_reset_reg)
            cfg_next = '0;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // Straps and decoded configuration clear together.
            pins_reg <= '0;
            cfg_reg <= '0;
        end
        else
        begin
            pins_reg <= pins_next;
            cfg_reg <= cfg_next;
        end
    end

    // Multiplexed bus decode. A write is taken on the first edge of its
    // strobe only; strobe_d_reg blocks repeats until the strobe is released.
    always_comb
    begin
        par_mode = pins_reg.mode_sel[1] && !in_reset_reg;
        strobe_act = !chip_sel_n && !data_strobe_n;
        if (pins_reg.mode_sel == MODE_PAR_STROBE)
        begin
            read_cyc = par_mode && strobe_act && rw_wr_n;
            write_cyc = par_mode && strobe_act && !rw_wr_n && !strobe_d_reg;
        end
        else
        begin
            // Separate strobes: read on data_strobe_n, write on rw_wr_n.
            read_cyc = par_mode && strobe_act;
            write_cyc = par_mode && !chip_sel_n && !rw_wr_n && !strobe_d_reg;
        end
    end

    always_comb
    begin
        addr_next = addr_reg;
        // The latch is honoured on every edge while it stays high; the last edge wins.
        if (par_mode && !chip_sel_n && addr_latch)
            addr_next = ad_in[2:0];
        strobe_d_next = write_cyc || (strobe_d_reg && par_mode &&
            !chip_sel_n && (!rw_wr_n || !data_strobe_n));
        // The drive enable is registered, so it lags the read strobe by one edge.
        ad_oe_next = read_cyc;
        // The drive value is cleared whenever the bus is not driven.
        ad_out_next = read_cyc ? rf_rdata : 8'h00;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            addr_reg <= 3'h0;
            strobe_d_reg <= 1'b0;
            ad_oe_reg <= 1'b0;
            ad_out_reg <= 8'h00;
        end
        else
        begin
            addr_reg <= addr_next;
            strobe_d_reg <= strobe_d_next;
            ad_oe_reg <= ad_oe_next;
            ad_out_reg <= ad_out_next;
        end
    end

    // The store sees the address as it is being latched, so its registered
    // read data already hold the latched word when the read strobe arrives.
    hwpcd_regfile u_regfile (
        .clock(clock),
        .rst_n(rst_n),
        .addr(addr_next),
        .wdata(ad_in),
        .we(write_cyc),
        .rdata(rf_rdata)
    );

    // Every output comes straight from its flop.
    assign ad_out = ad_out_reg;
    assign ad_oe = ad_oe_reg;
    assign cfg = cfg_reg;
    assign in_reset = in_reset_reg;
endmodule
`default_nettype wire

/* bench/hwpcd_properties.sv */
/*
 Port assertions of the pin configuration decoder.
 Assumes a bind from the bench top file and one clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
module hwpcd_properties
    import hwpcd_pkg::*;
(
    input wire logic clock, // core clock
    input wire logic rst_n, // reset, active low
    input wire hwpcd_pkg::hwpcd_pins_t pins, // strap pins
    input wire logic chip_sel_n, // bus select
    input wire logic data_strobe_n, // data or read strobe
    input wire logic [7:0] ad_out, // bus drive value
    input wire logic ad_oe, // bus drive enable
    input wire hwpcd_pkg::hwpcd_cfg_t cfg, // decoded configuration
    input wire logic in_reset // reset state
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence hw_sq;
        !in_reset && !$past(in_reset, 2) && $past(pins.mode_sel, 2) == MODE_HW;
    endsequence
    a_reach_decode: assert property (
        hw_sq |-> cfg.long_reach == $past(pins.equalizer_reach_sel, 2)
        && cfg.reach_db == (!$past(pins.equalizer_reach_sel, 2) ? REACH_SHORT_DB
        : $past(pins.e1_mode, 2) ? REACH_LONG_E1_DB : REACH_LONG_T1_DB))
        else $error("equalizer reach decode wrong");
    a_rx_powerdown: assert property (
        hw_sq |-> cfg.rx_powerdown == $past(pins.rx_powerdown_pin, 2))
        else $error("receiver power down decode wrong");
    a_tx_pattern: assert property (
        hw_sq |-> cfg.tx_pattern == $past(pins.tx_pattern_sel, 2))
        else $error("transmit pattern decode wrong");
    a_jit_decode: assert property (
        hw_sq |-> cfg.jit_enable == |$past(pins.jitter_atten_sel, 2)
        && cfg.jit_in_tx == &$past(pins.jitter_atten_sel, 2)
        && cfg.jit_narrow == $past(pins.jitter_atten_sel[1], 2)
        && cfg.jit_fifo_bits == (!(|$past(pins.jitter_atten_sel, 2)) ? 8'h00
        : $past(pins.jitter_atten_sel[1], 2) ? FIFO_DEPTH_128 : FIFO_DEPTH_64))
        else $error("jitter select decode wrong");
    a_jit_ignored: assert property (
        !in_reset && !$past(in_reset, 2) && $past(pins.mode_sel, 2) != MODE_HW
        |-> !cfg.hw_mode && !cfg.jit_enable && cfg.jit_fifo_bits == 8'h00)
        else $error("jitter select obeyed outside pin mode");
    a_reset_seq: assert property (
        $rose(rst_n) |-> in_reset && !ad_oe ##1 in_reset ##1 !in_reset)
        else $error("reset state sequence wrong");
    a_read_drive: assert property (
        pins.mode_sel == MODE_PAR_RDWR && $stable(pins.mode_sel) && !in_reset
        && !chip_sel_n && !data_strobe_n |=> ad_oe)
        else $error("read strobe not answered");
    a_drive_cause: assert property (
        ad_oe |-> !$past(data_strobe_n) && !$past(chip_sel_n) && $past(pins.mode_sel[1]))
        else $error("bus driven without read strobe");
    a_idle_out: assert property (
        !ad_oe |-> ad_out == 8'h00)
        else $error("drive value not cleared");
    c_read_strobes: cover property (ad_oe && pins.mode_sel == MODE_PAR_RDWR);
    c_read_dir: cover property (ad_oe && pins.mode_sel == MODE_PAR_STROBE);
    c_jit_tx: cover property (cfg.jit_in_tx && cfg.hw_mode);
endmodule
`default_nettype wire

/* bench/hwpcd_host.sv */
/*
 Host model on the multiplexed address/data bus.
 Assumes the bench calls xfer only after reset has settled.
*/
`timescale 1ns/10ps
`default_nettype none
module hwpcd_host (
    input wire logic clock, // core clock
    input wire logic [7:0] ad_out, // device drive value
    input wire logic ad_oe, // device drive enable
    output logic chip_sel_n, // bus select, active low
    output logic addr_latch, // address latch
    output logic data_strobe_n, // data or read strobe
    output logic rw_wr_n, // direction or write strobe
    output logic [7:0] ad_in // resolved bus level
);
    logic host_oe;
    logic [7:0] host_ad;
    logic [7:0] last_ad = 8'h00;
    // A released bus shows the inverse of its last level, never a stale copy.
    assign ad_in = ad_oe ? ad_out : host_oe ? host_ad : ~last_ad;
    always @(posedge clock) last_ad <= ad_in;
    initial {chip_sel_n, addr_latch, data_strobe_n, rw_wr_n, host_oe, host_ad} = 13'h1600;
    task automatic xfer(input logic strobes, input logic rd, input logic [2:0] a,
                        input logic [7:0] d, output logic [7:0] q);
        q = 8'h00;
        @(posedge clock);
        {chip_sel_n, addr_latch, host_oe, host_ad} <= {3'b011, 5'h00, a};
        @(posedge clock);
        {addr_latch, host_oe, host_ad} <= {1'b0, !rd, d};
        data_strobe_n <= strobes && !rd;
        rw_wr_n <= rd;
        @(posedge clock);
        if (rd)
        begin
            @(posedge clock);
            q = ad_in;
        end
        {chip_sel_n, data_strobe_n, rw_wr_n, host_oe} <= 4'he;
    endtask
endmodule
`default_nettype wire

/* bench/hwpcd_top_tb.sv */
/*
 Self-checking bench of the pin configuration decoder.
 Assumes the host model in hwpcd_host and the checker in hwpcd_properties.
*/
`timescale 1ns/10ps
`default_nettype none
module hwpcd_top_tb;
    import hwpcd_pkg::*;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    hwpcd_pins_t pins = '0;
    logic chip_sel_n, addr_latch, data_strobe_n, rw_wr_n, ad_oe, in_reset;
    logic [7:0] ad_in, ad_out, q;
    hwpcd_cfg_t cfg, want;
    int mismatches = 0;
    int checks = 0;
    always #50 clock = ~clock;
    hwpcd_top uut (.clock(clock), .rst_n(rst_n), .pins(pins), .chip_sel_n(chip_sel_n),
        .addr_latch(addr_latch), .data_strobe_n(data_strobe_n), .rw_wr_n(rw_wr_n),
        .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe), .cfg(cfg), .in_reset(in_reset));
    hwpcd_host host (.clock(clock), .ad_out(ad_out), .ad_oe(ad_oe), .chip_sel_n(chip_sel_n),
        .addr_latch(addr_latch), .data_strobe_n(data_strobe_n), .rw_wr_n(rw_wr_n),
        .ad_in(ad_in));
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    function automatic hwpcd_cfg_t decode(input hwpcd_pins_t p);
        hwpcd_cfg_t c;
        c.hw_mode = 1'b1;
        c.long_reach = p.equalizer_reach_sel;
        c.reach_db = !c.long_reach ? 6'h0a : p.e1_mode ? 6'h2b : 6'h24;
        c.rx_powerdown = p.rx_powerdown_pin;
        c.tx_pattern = hwpcd_txp_t'(p.tx_pattern_sel);
        c.jit_enable = |p.jitter_atten_sel;
        c.jit_in_tx = &p.jitter_atten_sel;
        c.jit_narrow = p.jitter_atten_sel[1];
        c.jit_fifo_bits = !c.jit_enable ? 8'h00 : c.jit_narrow ? 8'h80 : 8'h40;
        return c;
    endfunction
    task automatic set_pins(input hwpcd_pins_t p);
        @(posedge clock);
        pins <= p;
        repeat (3) @(posedge clock);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        #200us;
        mismatches++;
        tally_and_finish();
    end
    initial
    begin
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        for (int i = 0; i < 128; i++)
        begin
            set_pins(hwpcd_pins_t'({2'h0, i[6:0]}));
            check("cfg pin mode", decode(pins), cfg);
        end
        // Serial mode keeps the last reach, power and pattern but drops the jitter select.
        want = '{1'b0, 1'b1, 6'h2b, 1'b1, HWPCD_TXP_OFF, 1'b0, 1'b0, 1'b0, 8'h00};
        set_pins(hwpcd_pins_t'(9'h086));
        check("cfg serial mode", want, cfg);
        host.xfer(1'b1, 1'b0, 3'h2, 8'h5a, q);
        set_pins(hwpcd_pins_t'(9'h100));
        host.xfer(1'b0, 1'b1, 3'h2, 8'h00, q);
        check("refused write", 8'h00, q);
        for (int s = 0; s < 2; s++)
        begin
            set_pins(hwpcd_pins_t'({1'b1, 1'(s), 7'h00}));
            for (int a = 0; a < 8; a++)
                host.xfer(1'(s), 1'b0, 3'(a), 8'(a * 37) ^ {1'(s), 7'h55}, q);
            for (int a = 0; a < 8; a++)
            begin
                host.xfer(1'(s), 1'b1, 3'(a), 8'h00, q);
                check("read data", 8'(a * 37) ^ {1'(s), 7'h55}, q);
            end
        end
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        check("in_reset", 1, in_reset);
        check("ad_oe in reset", 0, ad_oe);
        check("cfg in reset", 0, cfg);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        host.xfer(1'b1, 1'b1, 3'h5, 8'h00, q);
        check("read after reset", 8'h00, q);
        tally_and_finish();
    end
endmodule
bind hwpcd_top hwpcd_properties chk (.clock(clock), .rst_n(rst_n), .pins(pins),
    .chip_sel_n(chip_sel_n), .data_strobe_n(data_strobe_n), .ad_out(ad_out),
    .ad_oe(ad_oe), .cfg(cfg), .in_reset(in_reset));
`default_nettype wire
